// >>> design/cem_map.vh
/*
 * constants for the coherent exclusive monitor: transaction kinds,
 * line states, response codes and shareability codes.
 * assumes inclusion by bare name from the design files.
 */
`ifndef CEM_MAP_VH
`define CEM_MAP_VH

// ----------------------------------------------------------------
// transaction kinds on the request output
// ----------------------------------------------------------------
`define CEM_TXN_W 3
`define CEM_TXN_READ_CLEAN 3'h0
`define CEM_TXN_READ_SHARED 3'h1
`define CEM_TXN_READ_NSD 3'h2
`define CEM_TXN_READ_UNIQUE 3'h3
`define CEM_TXN_CLEAN_UNIQUE 3'h4
`define CEM_TXN_READ_NOSNOOP 3'h5
`define CEM_TXN_WRITE_NOSNOOP 3'h6

// ----------------------------------------------------------------
// cache line state as seen by the monitor
// ----------------------------------------------------------------
`define CEM_LINE_INVALID 2'h0
`define CEM_LINE_SHARED 2'h1
`define CEM_LINE_UNIQUE 2'h2

// ----------------------------------------------------------------
// response codes
// ----------------------------------------------------------------
`define CEM_RESP_OKAY 2'h0
`define CEM_RESP_EXOKAY 2'h1

// ----------------------------------------------------------------
// shareability domain codes
// ----------------------------------------------------------------
`define CEM_DOM_NONSHARE 2'h0
`define CEM_DOM_INNER 2'h1
`define CEM_DOM_OUTER 2'h2
`define CEM_DOM_SYSTEM 2'h3

// ----------------------------------------------------------------
// operation codes on the core request port
// ----------------------------------------------------------------
`define CEM_OP_LOAD 2'h0
`define CEM_OP_STORE 2'h1
`define CEM_OP_ATOMIC 2'h2
`define CEM_OP_ABANDON 2'h3

// ----------------------------------------------------------------
// result codes
// ----------------------------------------------------------------
`define CEM_RES_PASS 2'h0
`define CEM_RES_FAIL 2'h1
`define CEM_RES_RESTART 2'h2

`endif

// >>> design/cem_addr_match.v
/*
 * line address compare helper for the monitor.
 * assumes addresses are synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module cem_addr_match #(
    parameter AW = 32,
    parameter LINE_BITS = 6
) (
    input wire [AW-1:0] a_i,
    input wire [AW-1:0] b_i,
    output wire match_o
);
    // --------------------------------------------------------------
    // compare only the line part of the address
    // --------------------------------------------------------------
    assign match_o = (a_i[AW-1:LINE_BITS] == b_i[AW-1:LINE_BITS]);
endmodule
`default_nettype wire

// >>> design/cem_snoop_filter.v
/*
 * classifies an incoming snoop: does it let another master store
 * to the watched line, i.e. does it invalidate our copy.
 * assumes snoop signals are one-cycle valid pulses on ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module cem_snoop_filter #(
    parameter AW = 32,
    parameter LINE_BITS = 6
) (
    input wire snp_valid_i,
    input wire snp_invalidating_i,
    input wire [AW-1:0] snp_addr_i,
    input wire [AW-1:0] mon_addr_i,
    input wire line_evicted_i,
    input wire [AW-1:0] evict_addr_i,
    output wire kill_o
);
    wire snp_hit;
    wire evict_hit;

    cem_addr_match #(.AW(AW), .LINE_BITS(LINE_BITS)) u_snp_match (
        .a_i(snp_addr_i),
        .b_i(mon_addr_i),
        .match_o(snp_hit)
    );

    cem_addr_match #(.AW(AW), .LINE_BITS(LINE_BITS)) u_evict_match (
        .a_i(evict_addr_i),
        .b_i(mon_addr_i),
        .match_o(evict_hit)
    );

    // --------------------------------------------------------------
    // invalidating snoop or loss of the line kills exclusivity
    // --------------------------------------------------------------
    assign kill_o = (snp_valid_i && snp_invalidating_i && snp_hit) ||
                    (line_evicted_i && evict_hit);
endmodule
`default_nettype wire

// >>> design/cem_monitor.v
/*
 * master-side exclusive access controller: local monitor, choice of
 * coherent transaction for exclusive load and store, and outcome.
 * assumes one outstanding core operation at a time, a bus that takes
 * a request with req_valid_o/req_ready_i and answers once with
 * rsp_valid_i; snoops arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cem_map.vh"

// Functional notes
// - local monitor set by exclusive load
// - invalidating snoop clears the monitor
// - evicted line counts as lost exclusivity
// - fetch only with ReadClean or ReadShared
// - exclusive load carries lock bit high
// - lock bit on load is optional
// - unique line: load completes locally
// - shared line: load transaction optional
// - sequence may be abandoned and restarted
// - monitor watches until the store
// - store fails if others may have stored
// - OKAY store transaction fails the store
// - non/system shareable: plain exclusive behaviour
// - same shareability for all exclusive masters
// - atomic update may use unmarked ReadUnique
// - clear monitor: fail store, no transaction
// - unique and set: pass without transaction
// - shared and set: locked CleanUnique
// - after EXOKAY recheck the monitor
module cem_monitor #(
    parameter AW = 32,
    parameter LINE_BITS = 6,
    parameter LOCK_ON_LOAD = 1,
    parameter LOAD_TXN_SHARED = 1
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire op_valid_i,
    input wire [1:0] op_code_i,
    input wire [AW-1:0] op_addr_i,
    input wire [1:0] op_domain_i,
    input wire [1:0] line_state_i,
    output reg op_done_o,
    output reg [1:0] op_result_o,
    output reg op_busy_o,
    output reg req_valid_o,
    output reg [2:0] req_txn_o,
    output reg req_lock_o,
    output reg [AW-1:0] req_addr_o,
    input wire req_ready_i,
    input wire rsp_valid_i,
    input wire [1:0] rsp_code_i,
    input wire snp_valid_i,
    input wire snp_invalidating_i,
    input wire [AW-1:0] snp_addr_i,
    input wire line_evicted_i,
    input wire [AW-1:0] evict_addr_i,
    output reg mon_set_o
);
    // --------------------------------------------------------------
    // state encoding
    // --------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ = 2'h1;
    localparam ST_WAIT = 2'h2;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [AW-1:0] mon_addr_ff;
    reg [AW-1:0] nxt_mon_addr;
    reg nxt_mon_set;
    reg [1:0] cur_op_ff;
    reg [1:0] nxt_cur_op;
    reg nxt_done;
    reg [1:0] nxt_result;
    reg nxt_req_valid;
    reg [2:0] nxt_req_txn;
    reg nxt_req_lock;
    reg [AW-1:0] nxt_req_addr;
    wire kill;
    wire op_hit;
    wire coherent;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function is_coherent;
        input [1:0] dom;
        begin
            is_coherent = (dom == `CEM_DOM_INNER) || (dom == `CEM_DOM_OUTER);
        end
    endfunction

    cem_snoop_filter #(.AW(AW), .LINE_BITS(LINE_BITS)) u_filter (
        .snp_valid_i(snp_valid_i),
        .snp_invalidating_i(snp_invalidating_i),
        .snp_addr_i(snp_addr_i),
        .mon_addr_i(mon_addr_ff),
        .line_evicted_i(line_evicted_i),
        .evict_addr_i(evict_addr_i),
        .kill_o(kill)
    );

    cem_addr_match #(.AW(AW), .LINE_BITS(LINE_BITS)) u_op_match (
        .a_i(op_addr_i),
        .b_i(mon_addr_ff),
        .match_o(op_hit)
    );

    // every master must use the same domain for one location
    assign coherent = is_coherent(op_domain_i);

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_mon_addr = mon_addr_ff;
        nxt_mon_set = mon_set_o;
        nxt_cur_op = cur_op_ff;
        nxt_done = 1'b0;
        nxt_result = op_result_o;
        nxt_req_valid = req_valid_o;
        nxt_req_txn = req_txn_o;
        nxt_req_lock = req_lock_o;
        nxt_req_addr = req_addr_o;
        // monitor keeps watching in every state; snoop/eviction clears it
        if (kill) begin
            nxt_mon_set = 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (op_valid_i) begin
                    nxt_cur_op = op_code_i;
                    nxt_req_addr = op_addr_i;
                    case (op_code_i)
                        `CEM_OP_LOAD: begin
                            nxt_mon_addr = op_addr_i;
                            nxt_mon_set = 1'b1;
                            if (!coherent) begin
                                // plain exclusive read
                                nxt_req_txn = `CEM_TXN_READ_NOSNOOP;
                                nxt_req_lock = 1'b1;
                                nxt_req_valid = 1'b1;
                                nxt_state = ST_REQ;
                            end else if (line_state_i == `CEM_LINE_UNIQUE ||
                                         line_state_i == `CEM_LINE_SHARED) begin
                                // held already: no bus
                                nxt_done = 1'b1;
                                nxt_result = `CEM_RES_PASS;
                            end else begin
                                nxt_req_txn = (LOAD_TXN_SHARED != 0) ?
                                    `CEM_TXN_READ_SHARED :
                                    `CEM_TXN_READ_CLEAN;
                                nxt_req_lock = (LOCK_ON_LOAD != 0);
                                nxt_req_valid = 1'b1;
                                nxt_state = ST_REQ;
                            end
                        end
                        `CEM_OP_STORE: begin
                            if (!coherent) begin
                                nxt_req_txn = `CEM_TXN_WRITE_NOSNOOP;
                                nxt_req_lock = 1'b1;
                                nxt_req_valid = 1'b1;
                                nxt_state = ST_REQ;
                            end else if (!mon_set_o || kill || !op_hit ||
                                         line_state_i == `CEM_LINE_INVALID) begin
                                nxt_mon_set = 1'b0;
                                nxt_done = 1'b1;
                                nxt_result = `CEM_RES_RESTART;
                            end else if (line_state_i == `CEM_LINE_UNIQUE) begin
                                nxt_done = 1'b1;
                                nxt_result = `CEM_RES_PASS;
                            end else begin
                                nxt_req_txn = `CEM_TXN_CLEAN_UNIQUE;
                                nxt_req_lock = 1'b1;
                                nxt_req_valid = 1'b1;
                                nxt_state = ST_REQ;
                            end
                        end
                        `CEM_OP_ATOMIC: begin
                            nxt_req_txn = `CEM_TXN_READ_UNIQUE;
                            nxt_req_lock = 1'b0;
                            nxt_req_valid = 1'b1;
                            nxt_state = ST_REQ;
                        end
                        default: begin
                            nxt_mon_set = 1'b0;
                            nxt_done = 1'b1;
                            nxt_result = `CEM_RES_PASS;
                        end
                    endcase
                end
            end
            ST_REQ: begin
                if (req_ready_i) begin
                    nxt_req_valid = 1'b0;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (rsp_valid_i) begin
                    nxt_done = 1'b1;
                    nxt_state = ST_IDLE;
                    nxt_req_lock = 1'b0;
                    if (cur_op_ff == `CEM_OP_STORE &&
                        req_txn_o == `CEM_TXN_CLEAN_UNIQUE) begin
                        if (rsp_code_i == `CEM_RESP_EXOKAY &&
                            mon_set_o && !kill) begin
                            nxt_result = `CEM_RES_PASS;
                        end else begin
                            nxt_mon_set = 1'b0;
                            nxt_result = `CEM_RES_RESTART;
                        end
                    end else if (cur_op_ff == `CEM_OP_STORE) begin
                        nxt_result = (rsp_code_i == `CEM_RESP_EXOKAY) ?
                            `CEM_RES_PASS : `CEM_RES_FAIL;
                        nxt_mon_set = 1'b0;
                    end else begin
                        // load answer: OKAY means no exclusive support
                        nxt_result = (cur_op_ff == `CEM_OP_LOAD &&
                            req_lock_o &&
                            rsp_code_i != `CEM_RESP_EXOKAY) ?
                            `CEM_RES_FAIL : `CEM_RES_PASS;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            mon_set_o <= 1'b0;
            mon_addr_ff <= {AW{1'b0}};
            cur_op_ff <= `CEM_OP_LOAD;
            op_done_o <= 1'b0;
            op_result_o <= `CEM_RES_PASS;
            op_busy_o <= 1'b0;
            req_valid_o <= 1'b0;
            req_txn_o <= `CEM_TXN_READ_CLEAN;
            req_lock_o <= 1'b0;
            req_addr_o <= {AW{1'b0}};
        end else begin
            state_ff <= nxt_state;
            mon_set_o <= nxt_mon_set;
            mon_addr_ff <= nxt_mon_addr;
            cur_op_ff <= nxt_cur_op;
            op_done_o <= nxt_done;
            op_result_o <= nxt_result;
            op_busy_o <= (nxt_state != ST_IDLE);
            req_valid_o <= nxt_req_valid;
            req_txn_o <= nxt_req_txn;
            req_lock_o <= nxt_req_lock;
            req_addr_o <= nxt_req_addr;
        end
    end
endmodule
`default_nettype wire

// >>> tb/cem_ic_model.sv
/* interconnect model with a serialization point monitor.
   assumes one request at a time from the master. */
`timescale 1ns/1ps
`default_nettype none
`include "cem_map.vh"
module cem_ic_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic valid_i,
    input wire logic [2:0] txn_i,
    input wire logic lock_i,
    input wire logic exok_i,
    input wire logic steal_i,
    input wire logic [3:0] wait_i,
    output logic ready_o,
    output logic rsp_o,
    output logic [1:0] code_o
);
// ------------------------------
// request, response and monitor
// ------------------------------
logic [3:0] cnt_ff;
logic busy_ff, cu_ff, lk_ff, reg_ff;
always @(posedge clk_i) begin
    ready_o <= 1'b0;
    rsp_o <= 1'b0;
    code_o <= ~code_o;
    cnt_ff <= cnt_ff + 4'h1;
    if (steal_i) reg_ff <= 1'b0;
    if (rst_i) begin
        busy_ff <= 1'b0;
        reg_ff <= 1'b0;
        cnt_ff <= 4'h0;
        code_o <= 2'h0;
    end else if (!busy_ff && valid_i && cnt_ff >= wait_i) begin
        ready_o <= 1'b1;
        busy_ff <= 1'b1;
        cnt_ff <= 4'h0;
        cu_ff <= txn_i == `CEM_TXN_CLEAN_UNIQUE;
        lk_ff <= lock_i;
    end else if (busy_ff && cnt_ff >= wait_i) begin
        rsp_o <= 1'b1;
        busy_ff <= 1'b0;
        cnt_ff <= 4'h0;
        code_o <= (exok_i && (!cu_ff || reg_ff)) ?
            `CEM_RESP_EXOKAY : `CEM_RESP_OKAY;
        if (lk_ff) reg_ff <= 1'b1;
    end else if (!valid_i && !busy_ff) cnt_ff <= 4'h0;
end
endmodule
`default_nettype wire

// >>> tb/cem_chk.sv
/* checker for cem_monitor ports.
   assumes binding from the testbench top file. */
`timescale 1ns/1ps
`default_nettype none
`include "cem_map.vh"
module cem_chk #(parameter AW = 32, parameter LINE_BITS = 6) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [1:0] op_code_i,
    input wire logic [AW-1:0] op_addr_i,
    input wire logic [1:0] op_domain_i,
    input wire logic [1:0] line_state_i,
    input wire logic op_done_o,
    input wire logic [1:0] op_result_o,
    input wire logic op_busy_o,
    input wire logic req_valid_o,
    input wire logic [2:0] req_txn_o,
    input wire logic req_lock_o,
    input wire logic req_ready_i,
    input wire logic rsp_valid_i,
    input wire logic [1:0] rsp_code_i,
    input wire logic snp_valid_i,
    input wire logic snp_invalidating_i,
    input wire logic [AW-1:0] snp_addr_i,
    input wire logic line_evicted_i,
    input wire logic [AW-1:0] evict_addr_i,
    input wire logic mon_set_o
);
// ------------------------------
// helpers and properties
// ------------------------------
default clocking @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
logic [AW-1:0] la_ff;
logic cu_ff, lk_ff;
wire ld = op_valid_i && !op_busy_o && op_code_i == `CEM_OP_LOAD;
wire st = op_valid_i && !op_busy_o && op_code_i == `CEM_OP_STORE;
wire coh = op_domain_i == `CEM_DOM_INNER || op_domain_i == `CEM_DOM_OUTER;
wire same = (op_addr_i >> LINE_BITS) == (la_ff >> LINE_BITS);
wire kill = (snp_valid_i && snp_invalidating_i &&
    (snp_addr_i >> LINE_BITS) == (la_ff >> LINE_BITS)) ||
    (line_evicted_i && (evict_addr_i >> LINE_BITS) == (la_ff >> LINE_BITS));
wire rsp = rsp_valid_i && !req_valid_o;
wire ex = rsp_code_i == `CEM_RESP_EXOKAY;
always @(posedge ref_clk_i) begin
    if (ld) la_ff <= op_addr_i;
    if (req_valid_o && req_ready_i) lk_ff <= req_lock_o;
    if (rst_i || op_done_o) cu_ff <= 1'b0;
    else if (req_valid_o && req_txn_o == `CEM_TXN_CLEAN_UNIQUE) cu_ff <= 1'b1;
end
rst_clear_a: assert property (disable iff (1'b0) rst_i |=> !mon_set_o &&
    !op_busy_o && !req_valid_o) else $error("reset left state");
load_sets_a: assert property (ld && coh |=> mon_set_o)
    else $error("load did not set monitor");
load_fetch_a: assert property (ld && coh && line_state_i == `CEM_LINE_INVALID
    |=> req_valid_o && req_lock_o && req_txn_o <= `CEM_TXN_READ_SHARED)
    else $error("bad fetch for load");
no_bad_lock_a: assert property (req_valid_o && req_lock_o |->
    !(req_txn_o inside {`CEM_TXN_READ_NSD, `CEM_TXN_READ_UNIQUE}))
    else $error("locked read removes copies");
snoop_kill_a: assert property (mon_set_o && kill && !ld |=> !mon_set_o)
    else $error("monitor survived kill");
store_clear_a: assert property (st && coh && !mon_set_o |=> op_done_o &&
    !req_valid_o && op_result_o != `CEM_RES_PASS) else $error("clear store");
store_uniq_a: assert property (st && coh && mon_set_o && !kill && same &&
    line_state_i == `CEM_LINE_UNIQUE |=> op_done_o && !req_valid_o &&
    op_result_o == `CEM_RES_PASS) else $error("unique store");
store_shared_a: assert property (st && coh && mon_set_o && !kill && same &&
    line_state_i == `CEM_LINE_SHARED |=> req_valid_o && req_lock_o &&
    req_txn_o == `CEM_TXN_CLEAN_UNIQUE) else $error("shared store");
okay_fail_a: assert property (op_busy_o && rsp && lk_ff && !ex |=>
    op_done_o && op_result_o != `CEM_RES_PASS) else $error("okay passed");
cu_recheck_a: assert property (cu_ff && rsp && ex && !mon_set_o |=>
    op_done_o && op_result_o != `CEM_RES_PASS) else $error("stale pass");
cu_pass_a: assert property (cu_ff && rsp && ex && mon_set_o && !kill |=>
    op_done_o && op_result_o == `CEM_RES_PASS) else $error("store lost");
cover property (cu_ff && rsp && ex);
cover property (mon_set_o && kill);
cover property (ld && line_state_i == `CEM_LINE_INVALID);
endmodule
`default_nettype wire

// >>> tb/tb.sv
/* top testbench for cem_monitor.
   assumes model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "cem_map.vh"
module tb;
// ------------------------------
// design, model and stimulus
// ------------------------------
localparam AW = 32;
localparam [AW-1:0] A = 32'h0000_1000;
logic ref_clk_i, rst_i, op_valid_i, op_done_o, op_busy_o, mon_set_o;
logic req_valid_o, req_lock_o, req_ready_i, rsp_valid_i;
logic snp_valid_i, snp_invalidating_i, line_evicted_i, exok, steal, rlk;
logic [1:0] op_code_i, op_domain_i, line_state_i, op_result_o, rsp_code_i;
logic [1:0] res;
logic [2:0] req_txn_o, rtxn;
logic [3:0] lat;
logic [AW-1:0] op_addr_i, req_addr_o, snp_addr_i, evict_addr_i, radr;
integer nreq = 0, nr = 0, miscompares = 0, total_checks = 0, cyc = 0;
cem_monitor dut (.*);
cem_ic_model ic (.clk_i(ref_clk_i), .rst_i(rst_i), .valid_i(req_valid_o),
    .txn_i(req_txn_o), .lock_i(req_lock_o), .exok_i(exok),
    .steal_i(steal), .wait_i(lat), .ready_o(req_ready_i),
    .rsp_o(rsp_valid_i), .code_o(rsp_code_i));
initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
end
always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
        miscompares = miscompares + 1;
        conclude;
    end
end
always @(posedge ref_clk_i) begin
    if (req_valid_o && req_ready_i) begin
        nreq <= nreq + 1;
        rtxn <= req_txn_o;
        rlk <= req_lock_o;
        radr <= req_addr_o;
    end
end
task conclude;
    begin
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    end
endtask
task op(input logic [1:0] c, input logic [1:0] ls, input logic [AW-1:0] a,
        input logic [1:0] d = `CEM_DOM_INNER);
    integer n, n0;
    begin
        n0 = nreq;
        op_code_i = c;
        line_state_i = ls;
        op_addr_i = a;
        op_domain_i = d;
        op_valid_i = 1'b1;
        @(posedge ref_clk_i);
        #1 op_valid_i = 1'b0;
        n = 0;
        while (op_done_o !== 1'b1 && n < 40) begin
            @(posedge ref_clk_i);
            #1 n = n + 1;
        end
        chk(n < 40, 1);
        res = op_result_o;
        nr = nreq - n0;
        @(posedge ref_clk_i);
        #1;
    end
endtask
task hit(input logic ev, input logic inv, input logic [AW-1:0] a);
    begin
        line_evicted_i = ev;
        evict_addr_i = a;
        snp_valid_i = !ev;
        snp_invalidating_i = inv;
        snp_addr_i = a;
        @(posedge ref_clk_i);
        #1 line_evicted_i = 1'b0;
        snp_valid_i = 1'b0;
    end
endtask
task t_load;
    begin
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A);
        chk(rtxn <= `CEM_TXN_READ_SHARED, 1);
        chk({nr[1:0], rlk}, 3'h3);
        chk(radr, A);
        chk(res, `CEM_RES_PASS);
        chk(mon_set_o, 1);
        op(`CEM_OP_STORE, `CEM_LINE_SHARED, A + 32'h8);
        chk({rtxn, rlk}, {`CEM_TXN_CLEAN_UNIQUE, 1'b1});
        chk(res, `CEM_RES_PASS);
    end
endtask
task t_local;
    begin
        op(`CEM_OP_LOAD, `CEM_LINE_SHARED, A);
        chk(nr, 0);
        op(`CEM_OP_LOAD, `CEM_LINE_UNIQUE, A);
        chk(nr, 0);
        op(`CEM_OP_STORE, `CEM_LINE_UNIQUE, A + 32'h4);
        chk({nr[1:0], res}, {2'h0, `CEM_RES_PASS});
    end
endtask
task t_steal;
    begin
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A);
        steal = 1'b1;
        @(posedge ref_clk_i);
        #1 steal = 1'b0;
        op(`CEM_OP_STORE, `CEM_LINE_SHARED, A);
        chk(rtxn, `CEM_TXN_CLEAN_UNIQUE);
        chk(res != `CEM_RES_PASS, 1);
    end
endtask
task t_snoop;
    begin
        op(`CEM_OP_LOAD, `CEM_LINE_SHARED, A);
        hit(1'b0, 1'b0, A);
        hit(1'b0, 1'b1, A + 32'h40);
        chk(mon_set_o, 1);
        hit(1'b0, 1'b1, A + 32'h4);
        chk(mon_set_o, 0);
        op(`CEM_OP_STORE, `CEM_LINE_UNIQUE, A);
        chk({nr[1:0], res != `CEM_RES_PASS}, 3'h1);
        op(`CEM_OP_LOAD, `CEM_LINE_SHARED, A);
        hit(1'b1, 1'b0, A);
        chk(mon_set_o, 0);
    end
endtask
task t_late;
    begin
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A);
        lat = 4'h4;
        fork
            op(`CEM_OP_STORE, `CEM_LINE_SHARED, A);
            begin
                repeat (3) @(posedge ref_clk_i);
                #1 hit(1'b0, 1'b1, A);
            end
        join
        lat = 4'h0;
        chk({nr[1:0], res != `CEM_RES_PASS}, 3'h3);
    end
endtask
task t_misc;
    begin
        exok = 1'b0;
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A, `CEM_DOM_OUTER);
        chk(res != `CEM_RES_PASS, 1);
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A, `CEM_DOM_NONSHARE);
        chk({rtxn, rlk}, {`CEM_TXN_READ_NOSNOOP, 1'b1});
        exok = 1'b1;
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A, `CEM_DOM_SYSTEM);
        chk(rtxn, `CEM_TXN_READ_NOSNOOP);
        op(`CEM_OP_ATOMIC, `CEM_LINE_INVALID, A);
        chk({rtxn, rlk}, {`CEM_TXN_READ_UNIQUE, 1'b0});
        op(`CEM_OP_ABANDON, `CEM_LINE_SHARED, A);
        chk(mon_set_o, 0);
        op(`CEM_OP_LOAD, `CEM_LINE_INVALID, A);
        chk({nr[1:0], res}, {2'h1, `CEM_RES_PASS});
        rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        chk(mon_set_o, 0);
    end
endtask
initial begin
    {op_valid_i, snp_valid_i, line_evicted_i, steal} = 4'h0;
    {op_code_i, op_domain_i, line_state_i} = 6'h0;
    {op_addr_i, snp_addr_i, evict_addr_i} = 96'h0;
    snp_invalidating_i = 1'b0;
    exok = 1'b1;
    lat = 4'h0;
    rst_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    t_load;
    t_local;
    t_steal;
    t_snoop;
    t_late;
    t_misc;
    conclude;
end
endmodule
bind cem_monitor cem_chk #(.AW(AW), .LINE_BITS(LINE_BITS)) chk_i (.*);
`default_nettype wire
